/* File: rpm_pkg.sv */
`default_nettype none

package rpm_pkg;
  // apb map, byte addresses of 32-bit words
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] LOCK_OFS = 8'h08;

  // control word fields
  localparam int CTRL_IDLE_BIT = 0;
  localparam int CTRL_PD_BIT = 1;
  localparam int CTRL_FRZ_BIT = 2;
  localparam int CTRL_WEN_LSB = 3;
  localparam int CTRL_LVL_LSB = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] LOCK_RESET = 2'h0;

  // status word fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_FETCH_BIT = 5;
  localparam int STAT_BLOCK_BIT = 6;
  localparam int STAT_RST_BIT = 7;

  // machine cycle timing, in oscillator periods
  localparam int OSC_PER_STATE = 2;
  localparam int STATES_PER_MCYCLE = 6;
  localparam int OSC_PER_MCYCLE = OSC_PER_STATE * STATES_PER_MCYCLE;
  localparam int RST_MCYCLES = 2;
  localparam int RST_HOLD_CLKS = RST_MCYCLES * OSC_PER_MCYCLE;
  localparam logic [2:0] LAST_STATE = 3'(STATES_PER_MCYCLE - 1);
  localparam logic [2:0] ALE_STATE_A = 3'h0;
  localparam logic [2:0] ALE_STATE_B = 3'h3;

  typedef enum logic [4:0] {
    RPM_RUN = 5'h01,
    RPM_IDLE = 5'h02,
    RPM_PDOWN = 5'h04,
    RPM_PDWAKE = 5'h08,
    RPM_EMUL = 5'h10
  } rpm_mode_e;
endpackage : rpm_pkg

`default_nettype wire

/* File: rpm_tim_if.sv */
`default_nettype none

// timing signals between the state sequencer and the mode control
interface rpm_tim_if;
  logic osc_run;
  logic restart;
  logic half_tick;
  logic cyc_end;
  logic [2:0] state;
  modport gen (input osc_run, input restart, output half_tick, output cyc_end, output state);
  modport ctl (output osc_run, output restart, input half_tick, input cyc_end, input state);
endinterface : rpm_tim_if

`default_nettype wire

/* File: rpm_sync2.sv */
`default_nettype none

module rpm_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // two flops; the first is seen by the second only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : rpm_sync2

`default_nettype wire

/* File: rpm_timing.sv */
`default_nettype none

module rpm_timing (
  input wire logic clk,
  input wire logic sys_rst,
  rpm_tim_if.gen tm
);
  import rpm_pkg::*;

  logic div_reg;
  logic [2:0] state_reg;

  // divide-by-two stage, so input duty cycle never matters
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg <= 1'b0;
    end else if (tm.restart) begin
      div_reg <= 1'b0;
    end else if (tm.osc_run) begin
      div_reg <= ~div_reg; // [R7]
    end
  end

  // six states per machine cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= 3'h0;
    end else if (tm.restart) begin
      state_reg <= 3'h0;
    end else if (tm.osc_run && div_reg) begin
      state_reg <= (state_reg == LAST_STATE) ? 3'h0 : state_reg + 3'h1;
    end
  end

  assign tm.half_tick = tm.osc_run & div_reg;
  assign tm.cyc_end = tm.half_tick & (state_reg == LAST_STATE);
  assign tm.state = state_reg;
endmodule : rpm_timing

`default_nettype wire

/* File: rpm_top.sv */
// Notes on behaviour
// R1: reset pin high two machine cycles with oscillator running resets the device.
// R2: latch strobe pulses at one sixth of the oscillator rate in normal running.
// R3: each external data access drops exactly one latch strobe pulse; an access in the cycle-end clock drops two.
// R4: program-store strobe twice per machine cycle; two dropped per data access; four if the access lands in the cycle-end clock.
// R5: fetch select low fetches externally over the whole space; high runs internally.
// R6: with a lock bit set, fetch select is latched at reset and held.
// R7: clocking passes through a divide-by-two stage, duty cycle is irrelevant.
// R8: idle halts execution; registers and ram keep their contents.
// R9: idle ends on reset or an enabled interrupt.
// R10: counter array runs or freezes in idle, as software selects.
// R11: power down stops the oscillator; requesting instruction is the last one.
// R12: power down ends on reset or external interrupt; reset clears registers only.
// R13: wake source asserted only after supply recovers, held until oscillator settles.
// R14: interrupt wake needs enabled level-sensitive line; low restarts, high completes.
// R15: after the wake handler, execution resumes after the power down instruction.
// R16: reset out of idle may run two cycles; ram blocked, ports not.
// R17: software should not write ports or external memory right after idle entry.
// R18: emulation entry: latch strobe low in reset with program strobe high.
// R19: emulation floats port 0, pulls others and strobes weakly; normal reset exits.
// R20: idle strobes high, power down low; port 0 floats externally; port 2 address.
// R21: a machine cycle is twelve oscillator periods, two latch pulses each.
//
// Local design decisions: the address map and register access over APB.
`default_nettype none

module rpm_top #(
  parameter int RST_HOLD = rpm_pkg::RST_HOLD_CLKS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rpm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin,
  input wire logic latch_strobe_pin_i,
  output logic latch_strobe_pin_o,
  output logic latch_strobe_pin_oe,
  input wire logic program_store_strobe_i,
  output logic program_store_strobe_o,
  output logic program_store_strobe_oe,
  input wire logic fetch_select_pin,
  input wire logic ext_interrupt_zero,
  input wire logic ext_interrupt_one,
  input wire logic xdata_access,
  input wire logic irq_pending,
  output logic core_reset,
  output logic cpu_run,
  output logic ram_block,
  output logic osc_run,
  output logic counter_array_run,
  output logic ext_fetch,
  output logic port0_float,
  output logic port2_address,
  output logic weak_pullup
);
  import rpm_pkg::*;

  localparam logic [4:0] HOLD_LAST = 5'(RST_HOLD - 1);

  rpm_tim_if tm ();
  rpm_mode_e mode_reg;
  logic rst_pin_s;
  logic ale_s;
  logic program_store_strobe_s;
  logic ea_s;
  logic [1:0] int_s;
  logic [4:0] cnt_reg;
  logic rst_active_reg;
  logic rst_rel;
  logic once_arm_reg;
  logic ea_lat_reg;
  logic [1:0] lock_reg;
  logic freeze_reg;
  logic [1:0] wake_en_reg;
  logic [1:0] level_reg;
  logic xd_pend_reg;
  logic skip_reg;
  logic block_reg;
  logic wake_low;
  logic normal;
  logic ale_pat;
  logic program_store_strobe_pat;
  logic ale_next;
  logic program_store_strobe_next;
  logic oe_next;
  logic wr_en;
  logic rd_hit;
  logic idle_wr;
  logic pd_wr;
  logic [31:0] rdata_next;

  // all pins cross into the clock domain through two flops
  rpm_sync2 #(
    .W(6)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({reset_pin, latch_strobe_pin_i, program_store_strobe_i, fetch_select_pin,
        ext_interrupt_one, ext_interrupt_zero}),
    .q({rst_pin_s, ale_s, program_store_strobe_s, ea_s, int_s})
  );

  rpm_timing u_timing (
    .clk(clk),
    .sys_rst(sys_rst),
    .tm(tm.gen)
  );

  // oscillator stops only while powered down
  assign osc_run = (mode_reg != RPM_PDOWN); // [R11]
  assign tm.osc_run = osc_run;
  assign tm.restart = rst_active_reg;

  // reset pin must stay high a full hold while clocks run
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 5'h00;
    end else if (!rst_pin_s || !osc_run) begin
      cnt_reg <= 5'h00;
    end else if (cnt_reg != HOLD_LAST) begin
      cnt_reg <= cnt_reg + 5'h01; // [R1]
    end
  end

  // internal reset holds until the pin falls
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_active_reg <= 1'b1;
    end else if (rst_pin_s && cnt_reg == HOLD_LAST) begin
      rst_active_reg <= 1'b1; // [R1]
    end else if (rst_rel) begin
      rst_active_reg <= 1'b0;
    end
  end
  assign rst_rel = rst_active_reg & ~rst_pin_s;
  assign core_reset = rst_active_reg;

  // emulation strap seen during reset: strobe low, program strobe high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      once_arm_reg <= 1'b0;
    end else if (rst_active_reg) begin
      once_arm_reg <= ~ale_s & program_store_strobe_s; // [R18]
    end
  end

  // fetch select caught at reset release, clocked, not by async reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ea_lat_reg <= 1'b0;
    end else if (rst_active_reg) begin
      ea_lat_reg <= ea_s; // [R6]
    end
  end
  // a lock bit freezes the strap; otherwise the live level counts
  assign ext_fetch = ~((|lock_reg) ? ea_lat_reg : ea_s); // [R5] [R6]

  // a level wake needs the line enabled and level sensitive
  assign wake_low = |(wake_en_reg & level_reg & ~int_s); // [R14]
  assign wr_en = psel & penable & pready & pwrite;
  assign idle_wr = wr_en && paddr == CTRL_OFS && pwdata[CTRL_IDLE_BIT];
  assign pd_wr = wr_en && paddr == CTRL_OFS && pwdata[CTRL_PD_BIT];

  // mode sequencing; power down wins over idle in one write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= RPM_RUN;
    end else if (rst_rel) begin
      mode_reg <= (once_arm_reg && !ale_s) ? RPM_EMUL : RPM_RUN; // [R18] [R19]
    end else if (!rst_active_reg) begin
      case (mode_reg)
        RPM_RUN: begin
          if (pd_wr) begin
            mode_reg <= RPM_PDOWN; // [R11]
          end else if (idle_wr) begin
            mode_reg <= RPM_IDLE; // [R8]
          end
        end
        RPM_IDLE: begin
          if (rst_pin_s || irq_pending) begin
            mode_reg <= RPM_RUN; // [R9]
          end
        end
        RPM_PDOWN: begin
          if (rst_pin_s || wake_low) begin
            mode_reg <= RPM_PDWAKE; // [R12] [R14]
          end
        end
        RPM_PDWAKE: begin
          // line back high completes the exit, code resumes in place
          if (!rst_pin_s && !wake_low) begin
            mode_reg <= RPM_RUN; // [R14] [R15]
          end
        end
        RPM_EMUL: begin
          mode_reg <= RPM_EMUL; // [R19]
        end
        default: begin
          mode_reg <= RPM_RUN;
        end
      endcase
    end
  end

  // reset out of idle: core runs briefly with ram fenced off
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      block_reg <= 1'b0;
    end else if (rst_active_reg || !rst_pin_s) begin
      block_reg <= 1'b0;
    end else if (mode_reg == RPM_IDLE) begin
      block_reg <= 1'b1; // [R16]
    end
  end
  assign ram_block = block_reg;

  // execution only in run; idle and power down keep state untouched
  assign cpu_run = (mode_reg == RPM_RUN) & ~rst_active_reg; // [R8] [R11] [R16]
  assign counter_array_run = ~rst_active_reg & ((mode_reg == RPM_RUN) | (mode_reg == RPM_EMUL)
                             | ((mode_reg == RPM_IDLE) & ~freeze_reg)); // [R10]

  // data access seen mid-cycle marks the next machine cycle; set wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xd_pend_reg <= 1'b0;
      skip_reg <= 1'b0;
    end else if (rst_active_reg) begin
      xd_pend_reg <= 1'b0;
      skip_reg <= 1'b0;
    end else begin
      xd_pend_reg <= xdata_access | (xd_pend_reg & ~tm.cyc_end);
      if (tm.cyc_end) begin
        skip_reg <= xd_pend_reg | xdata_access; // [R3] [R4]
      end
    end
  end

  // two latch pulses and two fetch strobes per twelve-period cycle
  assign normal = (mode_reg == RPM_RUN) & ~rst_active_reg;
  assign ale_pat = (tm.state == ALE_STATE_A) | ((tm.state == ALE_STATE_B) & ~skip_reg); // [R2] [R3] [R21]
  assign program_store_strobe_pat = ext_fetch & ~skip_reg & (tm.state != ALE_STATE_A)
                    & (tm.state != ALE_STATE_B); // [R4]

  // pin levels per mode; reset and emulation only pull weakly
  always_comb begin
    ale_next = 1'b1;
    program_store_strobe_next = 1'b1;
    oe_next = ~rst_active_reg & (mode_reg != RPM_EMUL); // [R19]
    case (mode_reg)
      RPM_RUN: begin
        ale_next = normal ? ale_pat : 1'b1;
        program_store_strobe_next = normal ? ~program_store_strobe_pat : 1'b1;
      end
      RPM_IDLE: begin
        ale_next = 1'b1; // [R20]
        program_store_strobe_next = 1'b1;
      end
      RPM_PDOWN, RPM_PDWAKE: begin
        ale_next = 1'b0; // [R20]
        program_store_strobe_next = 1'b0;
      end
      default: begin
        ale_next = 1'b1;
        program_store_strobe_next = 1'b1;
      end
    endcase
  end

  // strobes leave through flops to keep glitches off the pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      latch_strobe_pin_o <= 1'b1;
      program_store_strobe_o <= 1'b1;
      latch_strobe_pin_oe <= 1'b0;
      program_store_strobe_oe <= 1'b0;
    end else begin
      latch_strobe_pin_o <= ale_next;
      program_store_strobe_o <= program_store_strobe_next;
      latch_strobe_pin_oe <= oe_next;
      program_store_strobe_oe <= oe_next;
    end
  end

  // port states: port 0 floats in emulation and, on external fetch, in idle and power down; port 2 address in idle on external fetch
  assign port0_float = (mode_reg == RPM_EMUL) | (ext_fetch & ((mode_reg == RPM_IDLE)
                       | (mode_reg == RPM_PDOWN) | (mode_reg == RPM_PDWAKE))); // [R19] [R20]
  assign port2_address = ext_fetch & (mode_reg == RPM_IDLE); // [R20]
  assign weak_pullup = rst_active_reg | (mode_reg == RPM_EMUL); // [R19]

  // control word; internal reset clears it, ram-like lock does not
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      freeze_reg <= CTRL_RESET[CTRL_FRZ_BIT];
      wake_en_reg <= CTRL_RESET[CTRL_WEN_LSB +: 2];
      level_reg <= CTRL_RESET[CTRL_LVL_LSB +: 2];
    end else if (rst_active_reg) begin
      freeze_reg <= CTRL_RESET[CTRL_FRZ_BIT]; // [R12]
      wake_en_reg <= CTRL_RESET[CTRL_WEN_LSB +: 2];
      level_reg <= CTRL_RESET[CTRL_LVL_LSB +: 2];
    end else if (wr_en && paddr == CTRL_OFS) begin
      freeze_reg <= pwdata[CTRL_FRZ_BIT];
      wake_en_reg <= pwdata[CTRL_WEN_LSB +: 2];
      level_reg <= pwdata[CTRL_LVL_LSB +: 2];
    end
  end

  // lock bits survive the pin reset, like fuses
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_reg <= LOCK_RESET;
    end else if (wr_en && paddr == LOCK_OFS) begin
      lock_reg <= pwdata[1:0];
    end
  end

  // read mux
  assign rd_hit = (paddr == CTRL_OFS) | (paddr == STAT_OFS) | (paddr == LOCK_OFS);
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      CTRL_OFS: begin
        rdata_next[CTRL_IDLE_BIT] = (mode_reg == RPM_IDLE);
        rdata_next[CTRL_PD_BIT] = (mode_reg == RPM_PDOWN);
        rdata_next[CTRL_FRZ_BIT] = freeze_reg;
        rdata_next[CTRL_WEN_LSB +: 2] = wake_en_reg;
        rdata_next[CTRL_LVL_LSB +: 2] = level_reg;
      end
      STAT_OFS: begin
        rdata_next[STAT_MODE_LSB +: 5] = mode_reg;
        rdata_next[STAT_FETCH_BIT] = ext_fetch;
        rdata_next[STAT_BLOCK_BIT] = block_reg;
        rdata_next[STAT_RST_BIT] = rst_active_reg;
      end
      LOCK_OFS: begin
        rdata_next[1:0] = lock_reg;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // one wait state: ready in the second access cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~rd_hit;
      prdata <= (psel & penable & ~pready & ~pwrite) ? rdata_next : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_held;
    rst_pin_s && osc_run && !rst_active_reg;
  endsequence
  sequence s_idle_reset;
    mode_reg == RPM_IDLE && rst_pin_s && !rst_active_reg;
  endsequence

  // a fresh pin pulse never resets within its first three cycles
  property p_rst_min;
    $rose(rst_pin_s) ##0 s_held |=> !rst_active_reg [*3];
  endproperty
  a_rst_min: assert property (p_rst_min) else $error("reset taken too early"); // [R1]

  property p_rst_take;
    rst_pin_s && cnt_reg == HOLD_LAST |=> rst_active_reg;
  endproperty
  a_rst_take: assert property (p_rst_take) else $error("held reset not taken"); // [R1]

  // first fall after a mode change may start mid-phase, so it is left out
  property p_ale_low;
    $fell(latch_strobe_pin_o) && $past(normal) && $past(normal, 2) |-> (!latch_strobe_pin_o || !normal) [*4];
  endproperty
  a_ale_low: assert property (p_ale_low) else $error("latch pulses too close"); // [R2]

  property p_ale_skip;
    normal && skip_reg && tm.state == ALE_STATE_B |=> !latch_strobe_pin_o;
  endproperty
  a_ale_skip: assert property (p_ale_skip) else $error("latch pulse not dropped"); // [R3]

  property p_program_store_strobe;
    normal && ext_fetch && tm.state == 3'h1 |=> program_store_strobe_o == skip_reg;
  endproperty
  a_program_store_strobe: assert property (p_program_store_strobe) else $error("fetch strobe wrong"); // [R4]

  property p_idle_pins;
    mode_reg == RPM_IDLE |=> ##1 latch_strobe_pin_o && program_store_strobe_o
                                 || mode_reg != RPM_IDLE;
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("idle strobes not high"); // [R20]

  property p_pd_osc;
    $rose(mode_reg == RPM_PDOWN) |-> !osc_run && !cpu_run ##1 !program_store_strobe_o;
  endproperty
  a_pd_osc: assert property (p_pd_osc) else $error("power down left clocks running"); // [R11]

  property p_idle_exit;
    mode_reg == RPM_IDLE && irq_pending && !rst_active_reg |=> mode_reg == RPM_RUN;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle not left on interrupt"); // [R9]

  property p_freeze;
    mode_reg == RPM_IDLE && freeze_reg |-> !counter_array_run;
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter array ran while frozen"); // [R10]

  property p_idle_block;
    s_idle_reset |=> ram_block && cpu_run;
  endproperty
  a_idle_block: assert property (p_idle_block) else $error("ram not fenced after idle reset"); // [R16]
endmodule : rpm_top

`default_nettype wire

/* File: rpm_far_model.sv */
`default_nettype none

// far side: strobe pull-ups, emulator strap, wake source
module rpm_far_model #(
  parameter int STAB = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ls_o,
  input wire logic ls_oe,
  input wire logic ps_o,
  input wire logic ps_oe,
  input wire logic osc_run,
  input wire logic emul_req,
  input wire logic wake_req,
  output logic ls_pin,
  output logic ps_pin,
  output logic int_zero
);
  timeunit 1ns;
  timeprecision 100ps;
  logic wake_low;
  logic [7:0] stab_cnt;

  // undriven strobes settle at the weak pull-up level, except the latch strobe, held low while the emulator strap is requested
  assign ls_pin = ls_oe ? ls_o : !emul_req;
  assign ps_pin = ps_oe ? ps_o : 1'b1;
  assign int_zero = !wake_low;

  // wake level held until the oscillator has run a while, never released early
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_low <= 1'b0;
      stab_cnt <= 8'h00;
    end else begin
      stab_cnt <= (wake_low && osc_run) ? stab_cnt + 8'h01 : 8'h00;
      if (wake_req && !osc_run) begin
        wake_low <= 1'b1;
      end else if (stab_cnt == 8'(STAB)) begin
        wake_low <= 1'b0;
      end
    end
  end
endmodule : rpm_far_model

`default_nettype wire

/* File: reset_power_mode_control_test.sv */
`default_nettype none

module reset_power_mode_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  import rpm_pkg::*;
  localparam logic [31:0] WK = 32'h28;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic reset_pin = 1'b0;
  logic fetch_sel = 1'b0;
  logic xdata = 1'b0;
  logic irq = 1'b0;
  logic emul_req = 1'b0;
  logic wake_req = 1'b0;
  logic [31:0] prdata, q, lr, pf, rv;
  logic pready, pslverr, ls_pin, ls_o, ls_oe, ps_pin, ps_o, ps_oe, int_zero, e, fz, seen;
  logic core_reset, cpu_run, ram_block, osc_run, ca_run, ext_fetch, p0f, p2a, wpu;
  integer seed, error_cnt, tests_run, n, i;

  // short reset hold keeps the run brief
  rpm_top #(.RST_HOLD(4)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin(reset_pin), .latch_strobe_pin_i(ls_pin), .latch_strobe_pin_o(ls_o),
    .latch_strobe_pin_oe(ls_oe), .program_store_strobe_i(ps_pin), .program_store_strobe_o(ps_o),
    .program_store_strobe_oe(ps_oe), .fetch_select_pin(fetch_sel), .ext_interrupt_zero(int_zero),
    .ext_interrupt_one(1'b1), .xdata_access(xdata), .irq_pending(irq), .core_reset(core_reset),
    .cpu_run(cpu_run), .ram_block(ram_block), .osc_run(osc_run), .counter_array_run(ca_run),
    .ext_fetch(ext_fetch), .port0_float(p0f), .port2_address(p2a), .weak_pullup(wpu));

  rpm_far_model #(.STAB(16)) u_far (
    .clk(clk), .sys_rst(sys_rst), .ls_o(ls_o), .ls_oe(ls_oe), .ps_o(ps_o), .ps_oe(ps_oe),
    .osc_run(osc_run), .emul_req(emul_req), .wake_req(wake_req), .ls_pin(ls_pin),
    .ps_pin(ps_pin), .int_zero(int_zero));

  // one latch pulse per six clocks, less one per data access
  function automatic logic [31:0] exp_ls(input int k, input logic xd);
    return 32'(k / 6) - {31'h0, xd};
  endfunction : exp_ls

  // program strobe falls as often, two lost per data access
  function automatic logic [31:0] exp_ps(input int k, input logic xd);
    return 32'(k / 6) - {30'h0, xd, 1'b0};
  endfunction : exp_ps

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  // one transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd_q, output logic rd_e);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 16) begin
      error_cnt++;
      print_verdict();
    end
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] v;
    logic ev;
    apb(1'b0, a, 32'h0, v, ev);
    chk(v, x);
  endtask : rd

  // status polled over the bus, bounded
  task automatic poll(input logic [31:0] m, input logic [31:0] x);
    logic [31:0] v;
    logic ev;
    int k;
    for (k = 0; k < 60; k++) begin
      apb(1'b0, STAT_OFS, 32'h0, v, ev);
      if ((v & m) === x) break;
    end
    chk(v & m, x);
    if (k == 60) print_verdict();
  endtask : poll

  task automatic pin_rst(input int k, input logic x);
    @(posedge clk);
    reset_pin <= 1'b1;
    repeat (k) @(posedge clk);
    reset_pin <= 1'b0;
    #1 chk({31'h0, core_reset}, {31'h0, x});
  endtask : pin_rst

  // counts strobe edges over k clocks, optional data access at the start
  task automatic count(input int k, input logic xd, output logic [31:0] c_l, output logic [31:0] c_p);
    logic pl, pp;
    c_l = 32'h0;
    c_p = 32'h0;
    @(posedge clk);
    xdata <= xd;
    #1;
    pl = ls_o;
    pp = ps_o;
    repeat (k) begin
      @(posedge clk);
      xdata <= 1'b0;
      #1;
      if (ls_o === 1'b1 && pl === 1'b0) c_l++;
      if (ps_o === 1'b0 && pp === 1'b1) c_p++;
      pl = ls_o;
      pp = ps_o;
    end
  endtask : count

  initial begin
    forever #4 clk = ~clk;
  end

  initial begin
    seed = 32'h7e52;
    error_cnt = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    // register map, refused and read-only accesses
    poll(32'hff, 32'h21);
    rd(CTRL_OFS, CTRL_RESET);
    apb(1'b1, 8'h0c, 32'hffff_ffff, q, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, STAT_OFS, 32'h0, q, e);
    rv = $random(seed) | 32'h1;
    apb(1'b1, LOCK_OFS, rv, q, e);
    rd(LOCK_OFS, {30'h0, rv[1:0]});
    rd(STAT_OFS, 32'h21);
    $display("test registers done");
    // locked strap moves only through a reset
    fetch_sel <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk({31'h0, ext_fetch}, 32'h1);
    pin_rst(12, 1'b1);
    poll(32'hff, 32'h01);
    fetch_sel <= 1'b0;
    count(24, 1'b0, lr, pf);
    chk(pf, 32'h0);
    chk({31'h0, ext_fetch}, 32'h0);
    apb(1'b1, LOCK_OFS, 32'h0, q, e);
    pin_rst(2, 1'b0);
    repeat (6) @(posedge clk);
    #1 chk({31'h0, core_reset}, 32'h0);
    pin_rst(12, 1'b1);
    poll(32'hff, 32'h21);
    $display("test strap and reset done");
    // strobe cadence, random lengths, alternate data accesses
    for (i = 0; i < 4; i++) begin
      n = 36 + 6 * ($unsigned($random(seed)) % 4);
      count(n, i[0], lr, pf);
      chk(lr, exp_ls(n, i[0]));
      chk(pf, exp_ps(n, i[0]));
    end
    $display("test strobes done");
    // idle with random counter option
    fz = 1'($random(seed));
    chk({31'h0, ca_run}, 32'h1);
    apb(1'b1, CTRL_OFS, {29'h0, fz, 2'h1}, q, e);
    repeat (2) @(posedge clk);
    #1 chk({26'h0, cpu_run, ls_o, ps_o, ca_run, p2a, p0f}, {26'h0, 3'b011, !fz, 2'b11});
    rd(STAT_OFS, 32'h22);
    irq <= 1'b1;
    poll(32'hff, 32'h21);
    irq <= 1'b0;
    rd(CTRL_OFS, {29'h0, fz, 2'h0});
    // reset out of idle: brief run with ram blocked
    apb(1'b1, CTRL_OFS, 32'h1, q, e);
    repeat (2) @(posedge clk);
    reset_pin <= 1'b1;
    seen = 1'b0;
    for (i = 0; i < 40 && core_reset !== 1'b1; i++) begin
      @(posedge clk);
      #1 if ({cpu_run, ram_block, core_reset} === 3'b110) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h1);
    chk({31'h0, core_reset}, 32'h1);
    @(posedge clk);
    reset_pin <= 1'b0;
    poll(32'hff, 32'h21);
    $display("test idle done");
    // power down, woken by the interrupt line
    apb(1'b1, CTRL_OFS, WK | 32'h2, q, e);
    repeat (2) @(posedge clk);
    #1 chk({26'h0, osc_run, cpu_run, ls_o, ps_o, p2a, p0f}, 32'h1);
    rd(STAT_OFS, 32'h24);
    wake_req <= 1'b1;
    poll(32'h1f, 32'h08);
    wake_req <= 1'b0;
    poll(32'h1f, 32'h01);
    rd(CTRL_OFS, WK);
    // power down ended by the reset pin
    apb(1'b1, CTRL_OFS, WK | 32'h2, q, e);
    pin_rst(12, 1'b1);
    poll(32'hff, 32'h21);
    rd(CTRL_OFS, CTRL_RESET);
    $display("test power down done");
    // emulation isolate entry and exit
    emul_req <= 1'b1;
    pin_rst(12, 1'b1);
    poll(32'h9f, 32'h10);
    emul_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({27'h0, ls_oe, ps_oe, wpu, p0f, osc_run}, 32'h7);
    pin_rst(12, 1'b1);
    poll(32'hff, 32'h21);
    $display("test emulation done");
    print_verdict();
  end
endmodule : reset_power_mode_control_test

`default_nettype wire
